// ==== rtl/card_control_and_channel_enable.sv ====
// card control, customisation info and channel enable registers over apb
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module card_control_and_channel_enable #(
   parameter logic [7:0]  BASE_MOD  = 8'h00,
   parameter logic [7:0]  FRONT_MOD = 8'h00,
   parameter logic [7:0]  HUB_MOD   = 8'h00,
   parameter int unsigned NUM_CH    = 32
) (
   // clock, reset, enable
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic                      ce,
   // register bus
   input  wire card_ctrl_pkg::apb_req_t   apb_req,
   output card_ctrl_pkg::apb_rsp_t        apb_rsp,
   // acquired samples, same clock
   input  wire logic [31:0]               sample_in,
   input  wire logic                      sample_valid,
   // packed memory words
   output card_ctrl_pkg::pack_word_t      pack_out,
   output logic                           mem_data_valid,
   // board outputs and interrupt
   output logic                           trig_out_en,
   output logic                           clk_out_en,
   output logic [31:0]                    chan_mask,
   output logic                           irq
);

   ////////////////////////////////////////////////////////////////////////////
   // commanded reset

   logic soft_rst;
   logic rst_all;

   // same path as power-on reset, so nothing can survive it
   assign rst_all = !rst_n || (soft_rst && ce);

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic        access;
   logic        take;
   logic        wr;
   logic [15:0] addr;
   logic [31:0] wdata;
   logic [31:0] next_rdata;
   logic        next_err;
   logic        mask_ok;
   logic [5:0]  chan_count;
   logic [2:0]  irq_status;
   logic [2:0]  irq_enable;
   logic [1:0]  out_ctrl;
   logic [31:0] custom_word;

   assign access = apb_req.psel && apb_req.penable;
   assign take   = access && apb_rsp.pready;
   assign wr     = take && apb_req.pwrite && !apb_rsp.pslverr;
   assign addr   = apb_req.paddr;
   assign wdata  = apb_req.pwdata;

   // standard cards carry zero codes by default
   assign custom_word = {8'h00, HUB_MOD, FRONT_MOD, BASE_MOD};

   assign mask_ok = (wdata == card_ctrl_pkg::MASK_8CH)
                 || (wdata == card_ctrl_pkg::MASK_16CH)
                 || (wdata == card_ctrl_pkg::MASK_32CH);

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      case (addr)
         card_ctrl_pkg::ADDR_CUSTOM_MOD: begin
            next_rdata = custom_word;
            next_err   = apb_req.pwrite;
         end
         card_ctrl_pkg::ADDR_BOARD_COMMAND: begin
            // write-only: reads return zero
            next_err = apb_req.pwrite && (wdata != card_ctrl_pkg::CMD_BOARD_RESET);
         end
         card_ctrl_pkg::ADDR_CHAN_MASK_LO: begin
            next_rdata = chan_mask;
            next_err   = apb_req.pwrite && !mask_ok;
         end
         card_ctrl_pkg::ADDR_CHAN_MASK_HI: begin
            next_rdata = 32'h0000_0000;
            next_err   = apb_req.pwrite && (wdata != 32'h0000_0000);
         end
         card_ctrl_pkg::ADDR_CHAN_COUNT: begin
            next_rdata = {26'h0, chan_count};
            next_err   = apb_req.pwrite;
         end
         card_ctrl_pkg::ADDR_IRQ_STATUS: begin
            next_rdata = {29'h0, irq_status};
            next_err   = apb_req.pwrite;
         end
         card_ctrl_pkg::ADDR_IRQ_ENABLE: begin
            next_rdata = {29'h0, irq_enable};
         end
         card_ctrl_pkg::ADDR_IRQ_CLEAR: begin
            next_rdata = 32'h0000_0000;
         end
         card_ctrl_pkg::ADDR_OUT_CTRL: begin
            next_rdata = {30'h0, out_ctrl};
         end
         card_ctrl_pkg::ADDR_BOARD_STATUS: begin
            next_rdata = {31'h0, mem_data_valid};
            next_err   = apb_req.pwrite;
         end
         default: begin
            next_err = 1'b1;
         end
      endcase
   end

   // one wait state: answer registered the cycle after access begins
   always_ff @(posedge clk) begin
      if (rst_all) begin
         apb_rsp <= '0;
      end else if (ce) begin
         apb_rsp.pready  <= access && !apb_rsp.pready;
         apb_rsp.prdata  <= (access && !apb_rsp.pready) ? next_rdata : 32'h0000_0000;
         apb_rsp.pslverr <= access && !apb_rsp.pready && next_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command register

   logic cmd_reset_wr;
   logic cmd_bad_wr;

   assign cmd_reset_wr = wr && (addr == card_ctrl_pkg::ADDR_BOARD_COMMAND)
                      && (wdata == card_ctrl_pkg::CMD_BOARD_RESET);
   assign cmd_bad_wr   = take && apb_req.pwrite && apb_rsp.pslverr
                      && (addr == card_ctrl_pkg::ADDR_BOARD_COMMAND);

   // soft_rst itself only clears on power-on reset or after acting
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         soft_rst <= 1'b0;
      end else if (ce) begin
         soft_rst <= cmd_reset_wr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel enable mask and width

   logic   mask_wr;
   logic   mask_bad_wr;
   // width follows the accepted mask; other masks can never be stored
   card_ctrl_pkg::width_t width;

   assign mask_wr     = wr && (addr == card_ctrl_pkg::ADDR_CHAN_MASK_LO);
   assign mask_bad_wr = take && apb_req.pwrite && apb_rsp.pslverr
                     && (addr == card_ctrl_pkg::ADDR_CHAN_MASK_LO);

   always_ff @(posedge clk) begin
      if (rst_all) begin
         chan_mask <= card_ctrl_pkg::CHAN_MASK_RESET;
      end else if (ce && mask_wr) begin
         chan_mask <= wdata;
      end
   end

   always_comb begin
      case (chan_mask)
         card_ctrl_pkg::MASK_8CH:  width = card_ctrl_pkg::WIDTH_8;
         card_ctrl_pkg::MASK_16CH: width = card_ctrl_pkg::WIDTH_16;
         default:                  width = card_ctrl_pkg::WIDTH_32;
      endcase
   end

   count_ones #(
      .W  (NUM_CH),
      .CW (6)
   ) u_count (
      .bits  (chan_mask),
      .count (chan_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sample packing

   logic [63:0] next_acc;
   logic [63:0] acc;
   logic [2:0]  slot;
   logic        last;

   always_comb begin
      case (width)
         card_ctrl_pkg::WIDTH_8: begin
            next_acc = {sample_in[7:0], acc[63:8]};
            last     = (slot == 3'h7);
         end
         card_ctrl_pkg::WIDTH_16: begin
            next_acc = {sample_in[15:0], acc[63:16]};
            last     = (slot == 3'h3);
         end
         default: begin
            next_acc = {sample_in, acc[63:32]};
            last     = (slot == 3'h1);
         end
      endcase
   end

   // a mask change restarts the word so widths never mix
   always_ff @(posedge clk) begin
      if (rst_all || (ce && mask_wr)) begin
         acc      <= 64'h0000_0000_0000_0000;
         slot     <= 3'h0;
         pack_out <= '0;
      end else if (ce) begin
         pack_out.we <= sample_valid && last;
         if (sample_valid) begin
            acc  <= next_acc;
            slot <= last ? 3'h0 : slot + 3'h1;
            if (last) begin
               pack_out.data <= next_acc;
            end
         end
      end
   end

   // memory holds valid data once a word was stored
   always_ff @(posedge clk) begin
      if (rst_all) begin
         mem_data_valid <= 1'b0;
      end else if (ce && pack_out.we) begin
         mem_data_valid <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output control

   always_ff @(posedge clk) begin
      if (rst_all) begin
         out_ctrl <= card_ctrl_pkg::OUT_CTRL_RESET;
      end else if (ce && wr && addr == card_ctrl_pkg::ADDR_OUT_CTRL) begin
         out_ctrl <= wdata[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst_all) begin
         trig_out_en <= 1'b0;
         clk_out_en  <= 1'b0;
      end else if (ce) begin
         trig_out_en <= out_ctrl[card_ctrl_pkg::OUT_TRIG_BIT];
         clk_out_en  <= out_ctrl[card_ctrl_pkg::OUT_CLK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts

   logic [2:0] events;
   logic [2:0] clr_bits;
   logic [2:0] next_status;
   logic [2:0] next_enable;

   assign events = {pack_out.we, cmd_bad_wr, mask_bad_wr};
   assign clr_bits = (wr && addr == card_ctrl_pkg::ADDR_IRQ_CLEAR) ? wdata[2:0] : 3'h0;
   assign next_enable = (wr && addr == card_ctrl_pkg::ADDR_IRQ_ENABLE) ? wdata[2:0] : irq_enable;

   // set wins over a clear in the same cycle
   assign next_status = (irq_status & ~clr_bits) | events;

   always_ff @(posedge clk) begin
      if (rst_all) begin
         irq_status <= card_ctrl_pkg::IRQ_RESET;
         irq_enable <= card_ctrl_pkg::IRQ_RESET;
         irq        <= 1'b0;
      end else if (ce) begin
         irq_status <= next_status;
         irq_enable <= next_enable;
         irq        <= |(next_status & next_enable);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_custom_fields: assert property (
      ce && access && !apb_rsp.pready && !apb_req.pwrite && addr == card_ctrl_pkg::ADDR_CUSTOM_MOD && !soft_rst
      |=> apb_rsp.pready && apb_rsp.prdata[7:0] == BASE_MOD
          && apb_rsp.prdata[15:8] == FRONT_MOD && apb_rsp.prdata[23:16] == HUB_MOD)
      else $error("customisation fields misplaced");

   a_custom_top_zero: assert property (
      apb_rsp.pready && !apb_req.pwrite && addr == card_ctrl_pkg::ADDR_CUSTOM_MOD
      |-> apb_rsp.prdata[31:24] == 8'h00)
      else $error("customisation top byte not zero");

   a_reset_cmd: assert property (
      ce && cmd_reset_wr |=> soft_rst ##1 (!soft_rst || !$past(ce)))
      else $error("reset command not acted on");

   a_reset_defaults: assert property (
      soft_rst && ce |=> chan_mask == card_ctrl_pkg::CHAN_MASK_RESET
                      && irq_enable == 3'h0 && !apb_rsp.pready)
      else $error("settings not restored by reset command");

   a_mem_invalid: assert property (
      soft_rst && ce |=> !mem_data_valid)
      else $error("memory still valid after reset command");

   a_outputs_off: assert property (
      soft_rst && ce |=> !trig_out_en && !clk_out_en && !irq)
      else $error("outputs enabled after reset command");

   a_bad_mask_kept: assert property (
      ce && mask_bad_wr && !soft_rst
      |=> chan_mask == $past(chan_mask) && irq_status[card_ctrl_pkg::IRQ_BAD_MASK])
      else $error("illegal mask stored or not flagged");

   a_good_mask_read: assert property (
      ce && mask_wr && !soft_rst
      |=> chan_mask == $past(wdata)
          ##1 (chan_mask == $past(wdata, 2) || $past(ce && (mask_wr || soft_rst))))
      else $error("accepted mask not held");

   a_mask_legal: assert property (
      chan_mask == card_ctrl_pkg::MASK_8CH || chan_mask == card_ctrl_pkg::MASK_16CH
      || chan_mask == card_ctrl_pkg::MASK_32CH)
      else $error("stored mask is not a legal value");

   a_count_match: assert property (
      chan_count == 6'($countones(chan_mask)))
      else $error("channel count disagrees with mask");

   a_pack_width8: assert property (
      ce && width == card_ctrl_pkg::WIDTH_8 && sample_valid && slot == 3'h7 && !mask_wr && !soft_rst
      |=> pack_out.we && pack_out.data[63:56] == $past(sample_in[7:0]))
      else $error("byte packing wrong");

endmodule : card_control_and_channel_enable

// ==== rtl/card_ctrl_pkg.sv ====
// shared constants and types of the card control register group
//
// Functional notes
// - read-only customisation register flags custom base, front-end and hub changes
// - only customised cards report a non-zero code; standard cards read zero
// - bits 7..0 hold the base card modification code
// - bits 15..8 hold the front-end module modification code
// - bits 23..16 hold the hub module modification code
// - write-only command register carries board commands
// - writing the reset command resets the whole board
// - commanded reset acts exactly like the power-on reset
// - after commanded reset every setting returns to its default
// - commanded reset marks on-board sample memory contents invalid
// - commanded reset disables trigger output, clock output and all outputs
// - readable, writable channel mask with one bit per channel, up to 32
// - channel mask is 64 bits wide; bits above 32 stay zero
// - only masks for channels 0-7, 0-15 or 0-31 are accepted
// - any other mask is rejected with an error, stored mask unchanged
// - reading the mask returns the accepted value, even right after writing
// - samples are packed into memory words at the enabled data width

package card_ctrl_pkg;

   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_BOARD_COMMAND = 16'h0064;
   localparam logic [15:0] IDX_CUSTOM_MOD    = 16'h0c3a;
   localparam logic [15:0] IDX_CHAN_MASK_LO  = 16'h2af8;
   localparam logic [15:0] IDX_CHAN_MASK_HI  = 16'h2af9;
   localparam logic [15:0] IDX_CHAN_COUNT    = 16'h2b00;
   localparam logic [15:0] IDX_IRQ_STATUS    = 16'h0200;
   localparam logic [15:0] IDX_IRQ_ENABLE    = 16'h0201;
   localparam logic [15:0] IDX_IRQ_CLEAR     = 16'h0202;
   localparam logic [15:0] IDX_OUT_CTRL      = 16'h0203;
   localparam logic [15:0] IDX_BOARD_STATUS  = 16'h0204;

   localparam logic [15:0] ADDR_BOARD_COMMAND = {IDX_BOARD_COMMAND[13:0], 2'b00};
   localparam logic [15:0] ADDR_CUSTOM_MOD    = {IDX_CUSTOM_MOD[13:0], 2'b00};
   localparam logic [15:0] ADDR_CHAN_MASK_LO  = {IDX_CHAN_MASK_LO[13:0], 2'b00};
   localparam logic [15:0] ADDR_CHAN_MASK_HI  = {IDX_CHAN_MASK_HI[13:0], 2'b00};
   localparam logic [15:0] ADDR_CHAN_COUNT    = {IDX_CHAN_COUNT[13:0], 2'b00};
   localparam logic [15:0] ADDR_IRQ_STATUS    = {IDX_IRQ_STATUS[13:0], 2'b00};
   localparam logic [15:0] ADDR_IRQ_ENABLE    = {IDX_IRQ_ENABLE[13:0], 2'b00};
   localparam logic [15:0] ADDR_IRQ_CLEAR     = {IDX_IRQ_CLEAR[13:0], 2'b00};
   localparam logic [15:0] ADDR_OUT_CTRL      = {IDX_OUT_CTRL[13:0], 2'b00};
   localparam logic [15:0] ADDR_BOARD_STATUS  = {IDX_BOARD_STATUS[13:0], 2'b00};

   // commands
   localparam logic [31:0] CMD_BOARD_RESET = 32'h0000_0001;

   // legal channel masks
   localparam logic [31:0] MASK_8CH   = 32'h0000_00ff;
   localparam logic [31:0] MASK_16CH  = 32'h0000_ffff;
   localparam logic [31:0] MASK_32CH  = 32'hffff_ffff;
   localparam logic [31:0] CHAN_MASK_RESET = MASK_32CH;

   // customisation field positions
   localparam int unsigned MOD_W     = 8;
   localparam int unsigned BASE_LSB  = 0;
   localparam int unsigned FRONT_LSB = 8;
   localparam int unsigned HUB_LSB   = 16;

   // interrupt bits
   localparam int unsigned IRQ_W           = 3;
   localparam int unsigned IRQ_BAD_MASK    = 0;
   localparam int unsigned IRQ_BAD_CMD     = 1;
   localparam int unsigned IRQ_WORD_PACKED = 2;
   localparam logic [2:0]  IRQ_RESET       = 3'h0;

   // output control and board status bits
   localparam int unsigned OUT_TRIG_BIT    = 0;
   localparam int unsigned OUT_CLK_BIT     = 1;
   localparam logic [1:0]  OUT_CTRL_RESET  = 2'h0;
   localparam int unsigned STAT_MEM_VALID  = 0;

   // sample width selected by the mask
   typedef enum logic [1:0] {
      WIDTH_8  = 2'b00,
      WIDTH_16 = 2'b01,
      WIDTH_32 = 2'b11
   } width_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic        we;
      logic [63:0] data;
   } pack_word_t;

endpackage : card_ctrl_pkg

// ==== rtl/count_ones.sv ====
// population count of a bit vector
`timescale 1ns/1ps
module count_ones #(
   parameter int unsigned W  = 32,
   parameter int unsigned CW = 6
) (
   // operand
   input  wire logic [W-1:0]  bits,
   // result
   output logic      [CW-1:0] count
);

   always_comb begin
      count = '0;
      for (int i = 0; i < W; i++) begin
         count = count + CW'(bits[i]);
      end
   end

endmodule : count_ones

// ==== bench/card_control_and_channel_enable_bench.sv ====
// self-checking bench of the card control and channel enable registers
`timescale 1ns/1ps
module card_control_and_channel_enable_bench;
   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic                        clk          = 1'b0;
   logic                        rst_n        = 1'b0;
   logic                        ce           = 1'b1;
   card_ctrl_pkg::apb_req_t     apb_req      = '0;
   card_ctrl_pkg::apb_rsp_t     apb_rsp;
   logic [31:0]                 sample_in    = 32'h0;
   logic                        sample_valid = 1'b0;
   card_ctrl_pkg::pack_word_t   pack_out;
   logic                        mem_data_valid;
   logic                        trig_out_en;
   logic                        clk_out_en;
   logic [31:0]                 chan_mask;
   logic                        irq;
   int                          miscompares  = 0;
   int                          checks_done  = 0;
   logic [31:0]                 rd;
   logic                        err;
   // module codes: nonzero so that each byte lane is seen
   localparam logic [7:0]       BASE_C       = 8'h3c;
   localparam logic [7:0]       FRONT_C      = 8'h5a;
   localparam logic [7:0]       HUB_C        = 8'hc3;

   always #5 clk = ~clk;

   card_control_and_channel_enable #(.BASE_MOD(BASE_C), .FRONT_MOD(FRONT_C), .HUB_MOD(HUB_C), .NUM_CH(32))
   u_card_control_and_channel_enable (
      .clk(clk), .rst_n(rst_n), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .sample_in(sample_in), .sample_valid(sample_valid), .pack_out(pack_out),
      .mem_data_valid(mem_data_valid), .trig_out_en(trig_out_en), .clk_out_en(clk_out_en),
      .chan_mask(chan_mask), .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask : chk

   // entered just after a rising edge; leaves one idle cycle so psel drops cleanly
   task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wdata);
      int n;
      n = 0;
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      rd  = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      if (n >= 20) chk(1'b0, 1'b1, "apb answer never came");
      @(posedge clk);
   endtask : apb

   // one sample per edge, then wait bounded for the packed word
   task automatic feed(input int cnt, input logic [63:0] exp);
      int n;
      for (int i = 0; i < cnt; i++) begin
         sample_in    <= 32'ha1b2c300 + i;
         sample_valid <= 1'b1;
         @(posedge clk);
      end
      sample_valid <= 1'b0;
      n = 0;
      while (pack_out.we !== 1'b1 && n < 4) begin
         @(posedge clk);
         n++;
      end
      chk(pack_out.we, 1'b1, "word strobe");
      chk(pack_out.data, exp, "packed word");
      @(posedge clk);
      chk(mem_data_valid, 1'b1, "memory valid");
   endtask : feed

   ////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values;
      apb(1'b0, card_ctrl_pkg::ADDR_CUSTOM_MOD, 32'h0);
      chk(rd, {8'h00, HUB_C, FRONT_C, BASE_C}, "custom info");
      chk(err, 1'b0, "custom read err");
      apb(1'b1, card_ctrl_pkg::ADDR_CUSTOM_MOD, 32'h0);
      chk(err, 1'b1, "custom write refused");
      apb(1'b0, card_ctrl_pkg::ADDR_CUSTOM_MOD, 32'h0);
      chk(rd[23:0], {HUB_C, FRONT_C, BASE_C}, "custom kept");
      apb(1'b0, card_ctrl_pkg::ADDR_CHAN_MASK_LO, 32'h0);
      chk(rd, 32'hffffffff, "mask default");
      apb(1'b0, card_ctrl_pkg::ADDR_CHAN_COUNT, 32'h0);
      chk(rd, 32'd32, "count default");
      apb(1'b0, card_ctrl_pkg::ADDR_BOARD_COMMAND, 32'h0);
      chk({err, rd}, 33'h0, "command reads zero");
      apb(1'b0, 16'h0ffc, 32'h0);
      chk(err, 1'b1, "unmapped address");
      chk({trig_out_en, clk_out_en, mem_data_valid, irq}, 4'h0, "outputs idle");
      $display("test reset_values done");
   endtask : t_reset_values

   task automatic t_mask_codes;
      logic [31:0] masks [3] = '{32'h000000ff, 32'h0000ffff, 32'hffffffff};
      logic [31:0] bad   [4] = '{32'h0000000f, 32'h000001ff, 32'hfffffffe, 32'h0};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, card_ctrl_pkg::ADDR_CHAN_MASK_LO, masks[i]);
         chk(err, 1'b0, "legal mask");
         apb(1'b0, card_ctrl_pkg::ADDR_CHAN_MASK_LO, 32'h0);
         chk(rd, masks[i], "mask readback");
         chk(chan_mask, masks[i], "mask port");
         apb(1'b0, card_ctrl_pkg::ADDR_CHAN_COUNT, 32'h0);
         chk(rd, 32'd8 << i, "channel count");
      end
      apb(1'b1, card_ctrl_pkg::ADDR_CHAN_MASK_LO, 32'h0000ffff);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, card_ctrl_pkg::ADDR_CHAN_MASK_LO, bad[i]);
         chk(err, 1'b1, "bad mask refused");
         apb(1'b0, card_ctrl_pkg::ADDR_CHAN_MASK_LO, 32'h0);
         chk(rd, 32'h0000ffff, "mask unchanged");
      end
      apb(1'b1, card_ctrl_pkg::ADDR_CHAN_MASK_HI, 32'h00000001);
      chk(err, 1'b1, "upper half refused");
      apb(1'b0, card_ctrl_pkg::ADDR_CHAN_MASK_HI, 32'h0);
      chk(rd, 32'h0, "upper half zero");
      $display("test mask_codes done");
   endtask : t_mask_codes

   task automatic t_pack;
      logic [63:0] exp;
      apb(1'b1, card_ctrl_pkg::ADDR_CHAN_MASK_LO, 32'hffffffff);
      feed(2, {32'ha1b2c301, 32'ha1b2c300});
      apb(1'b1, card_ctrl_pkg::ADDR_CHAN_MASK_LO, 32'h0000ffff);
      feed(4, 64'hc303_c302_c301_c300);
      apb(1'b1, card_ctrl_pkg::ADDR_CHAN_MASK_LO, 32'h000000ff);
      for (int i = 0; i < 8; i++) exp[8*i +: 8] = 8'(i);
      feed(8, exp);
      apb(1'b0, card_ctrl_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(rd[2], 1'b1, "word packed status");
      $display("test pack done");
   endtask : t_pack

   task automatic t_irq;
      apb(1'b1, card_ctrl_pkg::ADDR_IRQ_CLEAR, 32'h7);
      apb(1'b1, card_ctrl_pkg::ADDR_IRQ_ENABLE, 32'h1);
      chk(irq, 1'b0, "irq quiet");
      apb(1'b1, card_ctrl_pkg::ADDR_CHAN_MASK_LO, 32'h00000003);
      chk(irq, 1'b1, "irq on bad mask");
      apb(1'b0, card_ctrl_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(rd[0], 1'b1, "bad mask status");
      apb(1'b1, card_ctrl_pkg::ADDR_IRQ_CLEAR, 32'h1);
      chk(irq, 1'b0, "irq cleared");
      apb(1'b1, card_ctrl_pkg::ADDR_IRQ_ENABLE, 32'h0);
      apb(1'b1, card_ctrl_pkg::ADDR_BOARD_COMMAND, 32'h2);
      chk(err, 1'b1, "bad command refused");
      chk(irq, 1'b0, "irq masked");
      apb(1'b0, card_ctrl_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(rd[1:0], 2'b10, "bad command status");
      $display("test irq done");
   endtask : t_irq

   task automatic t_cmd_reset;
      apb(1'b1, card_ctrl_pkg::ADDR_OUT_CTRL, 32'h3);
      apb(1'b1, card_ctrl_pkg::ADDR_IRQ_ENABLE, 32'h7);
      chk({trig_out_en, clk_out_en, irq}, 3'b111, "outputs on");
      apb(1'b1, card_ctrl_pkg::ADDR_BOARD_COMMAND, card_ctrl_pkg::CMD_BOARD_RESET);
      chk(err, 1'b0, "reset command taken");
      repeat (2) @(posedge clk);
      chk({trig_out_en, clk_out_en}, 2'b00, "outputs off");
      chk(mem_data_valid, 1'b0, "memory invalid");
      chk(chan_mask, 32'hffffffff, "mask to default");
      chk(irq, 1'b0, "irq off after reset");
      apb(1'b0, card_ctrl_pkg::ADDR_OUT_CTRL, 32'h0);
      chk(rd, 32'h0, "out ctrl default");
      apb(1'b0, card_ctrl_pkg::ADDR_IRQ_ENABLE, 32'h0);
      chk(rd, 32'h0, "irq enable default");
      apb(1'b0, card_ctrl_pkg::ADDR_BOARD_STATUS, 32'h0);
      chk(rd[0], 1'b0, "status memory invalid");
      $display("test cmd_reset done");
   endtask : t_cmd_reset

   ////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results

   // whole run is well under two thousand cycles
   initial begin
      #200000;
      miscompares++;
      results();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b1, card_ctrl_pkg::ADDR_BOARD_COMMAND, card_ctrl_pkg::CMD_BOARD_RESET);
      chk(err, 1'b0, "start-up reset command");
      repeat (2) @(posedge clk);
      t_reset_values();
      t_mask_codes();
      t_pack();
      t_irq();
      t_cmd_reset();
      results();
   end
endmodule : card_control_and_channel_enable_bench
